// ==== rtl/lfb_pkg.sv ====
package lfb_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned TBL_W = 32;
	localparam int unsigned SEL_W = 5;
	localparam int unsigned CNT_W = 5;
	localparam int unsigned SUB_W = 8;
	localparam logic [7:0] SUB_MAX_SMALL = 8'h0F;
	localparam logic [7:0] SUB_MAX_LARGE = 8'hFF;
	localparam int unsigned DEPTH_LARGE = 3;
	localparam int unsigned DEPTH_W = 2;
	localparam int unsigned LOOP_W = 15;
	localparam logic [14:0] LOOP_MAX = 15'h7FFF;
	localparam logic [14:0] LOOP_MIN = 15'h0001;
	localparam int unsigned IRQ_W = 2;
	localparam logic [1:0] RST_PEND = 2'h0;
	localparam logic RST_IRQ_EN = 1'b0;

	typedef enum logic [2:0] {
		LFB_OP_NONE = 3'b000,
		LFB_OP_EXPAND = 3'b001,
		LFB_OP_TALLY = 3'b010,
		LFB_OP_CALL = 3'b011,
		LFB_OP_EXIT = 3'b100,
		LFB_OP_LOOP = 3'b101,
		LFB_OP_NEXT = 3'b110,
		LFB_OP_IRQ = 3'b111
	} lfb_op_t;
endpackage : lfb_pkg

// ==== rtl/lfb_alu_if.sv ====
`timescale 1ns/10ps
interface lfb_alu_if;
	import lfb_pkg::*;
	logic [DATA_W-1:0] src;
	logic [SEL_W-1:0] sel;
	logic [TBL_W-1:0] table_v;
	logic [CNT_W-1:0] tally;
	modport core(output src, output sel, input table_v, input tally);
	modport alu(input src, input sel, output table_v, output tally);
endinterface : lfb_alu_if

// ==== rtl/lfb_alu.sv ====
`timescale 1ns/10ps
module lfb_alu
	import lfb_pkg::*;
(
	lfb_alu_if.alu bus
);
	logic [CNT_W-1:0] sum [DATA_W+1];
	assign sum[0] = '0;
	// Per-bit decode and tally chain
	for (genvar i = 0; i < TBL_W; i++) begin : g_bit
		assign bus.table_v[i] = (bus.sel == SEL_W'(i));
		if (i < DATA_W) begin : g_cnt
			assign sum[i+1] = sum[i] + CNT_W'(bus.src[i]);
		end
	end
	assign bus.tally = sum[DATA_W];
endmodule : lfb_alu

// ==== rtl/lfb_core.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Expand selects one table bit, clears rest
// - Tally counts ones of source word
// - Call jumps to numbered subroutine
// - Call output OFF, and OFF again at return
// - Numbers 0-15 small, 0-255 large
// - Large model nests calls three deep
// - Exit resumes at invoking call
// - Loop input OFF runs segment once
// - Next input OFF breaks loop immediately
// - Allow enables timer and I/O interrupts
// - Lowest pending cause serviced after allow when none runs; next after done
// - Block stops timer and I/O interrupts
module lfb_core
	import lfb_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic large_model_i,
	input wire logic exec_i,
	input wire lfb_op_t op_i,
	input wire logic rung_in_i,
	input wire logic irq_off_i,
	input wire logic [DATA_W-1:0] src_i,
	input wire logic [SUB_W-1:0] sub_num_i,
	input wire logic [LOOP_W-1:0] loop_n_i,
	input wire logic [IRQ_W-1:0] irq_cause_i,
	input wire logic irq_done_i,
	output logic rung_out_o,
	output logic [TBL_W-1:0] table_o,
	output logic [DATA_W-1:0] tally_o,
	output logic jump_o,
	output logic [SUB_W-1:0] jump_sub_o,
	output logic resume_o,
	output logic call_err_o,
	output logic [DEPTH_W-1:0] depth_o,
	output logic loop_back_o,
	output logic loop_exit_o,
	output logic irq_en_o,
	output logic [IRQ_W-1:0] irq_pend_o,
	output logic irq_run_o,
	output logic [IRQ_W-1:0] irq_sel_o
);
	lfb_alu_if alu_bus();
	lfb_alu u_alu (
		.bus(alu_bus.alu)
	);
	assign alu_bus.src = src_i;
	assign alu_bus.sel = src_i[SEL_W-1:0];

	////////////////////////////////////////////////////////////////
	// Decode
	wire go = exec_i && rung_in_i;
	wire do_expand = go && (op_i == LFB_OP_EXPAND);
	wire do_tally = go && (op_i == LFB_OP_TALLY);
	wire do_call_req = go && (op_i == LFB_OP_CALL);
	wire do_exit = exec_i && (op_i == LFB_OP_EXIT);
	wire do_loop = exec_i && (op_i == LFB_OP_LOOP);
	wire do_next = exec_i && (op_i == LFB_OP_NEXT);
	wire do_irq = go && (op_i == LFB_OP_IRQ);
	wire [SUB_W-1:0] sub_max = large_model_i ? SUB_MAX_LARGE : SUB_MAX_SMALL;
	wire [DEPTH_W-1:0] depth_max = large_model_i ? DEPTH_W'(DEPTH_LARGE) : DEPTH_W'(1);
	logic [DEPTH_W-1:0] depth_q;
	wire num_ok = (sub_num_i <= sub_max);
	wire room = (depth_q < depth_max);
	wire do_call = do_call_req && num_ok && room;
	wire pop = do_exit && (depth_q != '0);
	// Rung output is off for any non-executed instruction
	wire out_d = do_exit ? 1'b0 : do_loop ? rung_in_i : do_next ? rung_in_i : go && !(do_call_req && !do_call);

	////////////////////////////////////////////////////////////////
	// Data results
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			table_o <= '0;
			tally_o <= '0;
			rung_out_o <= 1'b0;
		end else begin
			rung_out_o <= out_d && !do_call;
			if (do_expand) table_o <= alu_bus.table_v;
			if (do_tally) tally_o <= DATA_W'(alu_bus.tally);
		end
	end

	////////////////////////////////////////////////////////////////
	// Call stack: return is answered on resume_o, output OFF with it
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			depth_q <= '0;
			jump_o <= 1'b0;
			jump_sub_o <= '0;
			resume_o <= 1'b0;
			call_err_o <= 1'b0;
		end else begin
			jump_o <= do_call;
			if (do_call) jump_sub_o <= sub_num_i;
			resume_o <= pop;
			call_err_o <= do_call_req && !do_call;
			if (do_call) depth_q <= depth_q + DEPTH_W'(1);
			else if (pop) depth_q <= depth_q - DEPTH_W'(1);
		end
	end
	assign depth_o = depth_q;

	////////////////////////////////////////////////////////////////
	// Counted loop; one loop at a time since nesting is barred
	logic [LOOP_W-1:0] left_q;
	logic active_q;
	wire [LOOP_W-1:0] n_clip = (loop_n_i == '0) ? LOOP_MIN : (loop_n_i > LOOP_MAX) ? LOOP_MAX : loop_n_i;
	wire again = active_q && rung_in_i && (left_q > LOOP_MIN);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			left_q <= '0;
			active_q <= 1'b0;
			loop_back_o <= 1'b0;
			loop_exit_o <= 1'b0;
		end else begin
			loop_back_o <= do_next && again;
			loop_exit_o <= do_next && !again;
			if (do_loop) begin
				left_q <= rung_in_i ? n_clip : LOOP_MIN;
				active_q <= 1'b1;
			end else if (do_next) begin
				left_q <= again ? left_q - LOOP_MIN : '0;
				active_q <= again;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt gate; a cause that lands on the service edge stays pending
	logic [IRQ_W-1:0] pend_q;
	logic en_q;
	logic run_q;
	wire take = en_q && !run_q && (pend_q != '0);
	wire [IRQ_W-1:0] pick = pend_q & (~pend_q + IRQ_W'(1));
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pend_q <= RST_PEND;
			en_q <= RST_IRQ_EN;
			run_q <= 1'b0;
			irq_sel_o <= '0;
		end else begin
			if (do_irq) en_q <= !irq_off_i;
			pend_q <= (pend_q & ~(take ? pick : '0)) | irq_cause_i;
			if (take) irq_sel_o <= pick;
			if (take) run_q <= 1'b1;
			else if (irq_done_i) run_q <= 1'b0;
		end
	end
	assign irq_en_o = en_q;
	assign irq_pend_o = pend_q;
	assign irq_run_o = run_q;

	////////////////////////////////////////////////////////////////
	// Checks
	a_expand_onehot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_expand |=> (table_o == (TBL_W'(1) << $past(src_i[SEL_W-1:0]))))
		else $error("table not one-hot at selector");
	a_tally_value: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_tally |=> (tally_o == DATA_W'($countones($past(src_i)))))
		else $error("tally mismatch");
	a_tally_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		tally_o <= DATA_W'(DATA_W))
		else $error("tally above 16");
	a_call_jump: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_call |=> jump_o && (jump_sub_o == $past(sub_num_i)))
		else $error("call did not jump");
	a_call_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		jump_o |-> (jump_sub_o <= (large_model_i ? SUB_MAX_LARGE : SUB_MAX_SMALL)))
		else $error("subroutine number out of range");
	a_depth_limit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		depth_q <= (large_model_i ? DEPTH_W'(DEPTH_LARGE) : DEPTH_W'(1)))
		else $error("nesting too deep");
	a_exit_resume: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		pop |=> resume_o && (depth_q == $past(depth_q) - DEPTH_W'(1)))
		else $error("exit did not resume");
	a_resume_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		resume_o |-> $past(do_exit) && ($past(depth_q) != '0) && !jump_o)
		else $error("resume without a pending return");
	a_loop_once: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_loop && !rung_in_i |=> (left_q == LOOP_MIN))
		else $error("off loop not single pass");
	a_loop_break: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_next && !rung_in_i |=> loop_exit_o && !active_q)
		else $error("loop not broken");
	a_loop_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_loop && rung_in_i |=> (left_q == $past(n_clip)) && (left_q >= LOOP_MIN))
		else $error("loop count wrong");
	a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!en_q |=> !$rose(run_q))
		else $error("interrupt ran while blocked");
	a_irq_pending: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_irq && !irq_off_i && (pend_q != '0) && !run_q |=> ##1 run_q)
		else $error("pending not serviced after allow");
	c_call_return: cover property (@(posedge sys_clk_i) disable iff (rst_i) jump_o ##[1:20] resume_o);
	c_depth_three: cover property (@(posedge sys_clk_i) disable iff (rst_i) depth_q == DEPTH_W'(DEPTH_LARGE));
	c_loop_back: cover property (@(posedge sys_clk_i) disable iff (rst_i) loop_back_o ##[1:10] loop_exit_o);
	c_irq_serviced: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(run_q));
endmodule : lfb_core

// ==== verif/tb_ladder_flow_and_bit_ops.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_ladder_flow_and_bit_ops
	import lfb_pkg::*;
;
	logic sys_clk_i, rst_i, large_model_i, exec_i, rung_in_i, irq_off_i, irq_done_i;
	lfb_op_t op_i;
	logic [15:0] src_i;
	logic [7:0] sub_num_i;
	logic [14:0] loop_n_i;
	logic [1:0] irq_cause_i;
	logic rung_out_o, jump_o, resume_o, call_err_o, loop_back_o, loop_exit_o, irq_en_o, irq_run_o;
	logic [31:0] table_o;
	logic [15:0] tally_o;
	logic [7:0] jump_sub_o;
	logic [1:0] depth_o, irq_pend_o, irq_sel_o;
	int n_mismatch = 0;
	int comparisons = 0;

	lfb_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .large_model_i(large_model_i), .exec_i(exec_i),
		.op_i(op_i), .rung_in_i(rung_in_i), .irq_off_i(irq_off_i), .src_i(src_i), .sub_num_i(sub_num_i),
		.loop_n_i(loop_n_i), .irq_cause_i(irq_cause_i), .irq_done_i(irq_done_i), .rung_out_o(rung_out_o),
		.table_o(table_o), .tally_o(tally_o), .jump_o(jump_o), .jump_sub_o(jump_sub_o), .resume_o(resume_o),
		.call_err_o(call_err_o), .depth_o(depth_o), .loop_back_o(loop_back_o), .loop_exit_o(loop_exit_o),
		.irq_en_o(irq_en_o), .irq_pend_o(irq_pend_o), .irq_run_o(irq_run_o), .irq_sel_o(irq_sel_o));

	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test

	// Operand fans out to every field; the op decides which one counts
	task automatic run(input lfb_op_t o, input logic r, input logic [15:0] d);
		@(posedge sys_clk_i);
		exec_i <= 1'b1;
		op_i <= o;
		rung_in_i <= r;
		src_i <= d;
		sub_num_i <= d[7:0];
		loop_n_i <= d[14:0];
		irq_off_i <= d[0];
		@(posedge sys_clk_i);
		exec_i <= 1'b0;
		#1;
	endtask : run

	function automatic logic [15:0] ones(input logic [15:0] v);
		ones = 16'h0000;
		for (int i = 0; i < 16; i++) ones += 16'(v[i]);
	endfunction : ones

	////////////////////////////////////////////////////////////////
	task automatic chk_expand();
		int sv[3] = '{0, 7, 31};
		foreach (sv[i]) begin
			run(LFB_OP_EXPAND, 1'b1, 16'hFFE0 | 16'(sv[i]));
			`CHK(table_o, 32'h1 << sv[i])
			`CHK(rung_out_o, 1'b1)
		end
		run(LFB_OP_EXPAND, 1'b0, 16'h0003);
		`CHK({table_o, rung_out_o}, {32'h80000000, 1'b0})
	endtask : chk_expand

	task automatic chk_tally();
		logic [15:0] v[3] = '{16'h0000, 16'hFFFF, 16'hA5A4};
		foreach (v[i]) begin
			run(LFB_OP_TALLY, 1'b1, v[i]);
			`CHK(tally_o, ones(v[i]))
			`CHK(rung_out_o, 1'b1)
		end
		// Input off keeps the old count
		run(LFB_OP_TALLY, 1'b0, 16'hFFFF);
		`CHK({tally_o, rung_out_o}, {ones(16'hA5A4), 1'b0})
	endtask : chk_tally

	task automatic chk_calls();
		@(posedge sys_clk_i);
		large_model_i <= 1'b0;
		run(LFB_OP_CALL, 1'b1, 16'h0010);
		`CHK({call_err_o, jump_o}, 2'h2)
		run(LFB_OP_CALL, 1'b0, 16'h0001);
		`CHK({call_err_o, jump_o, rung_out_o}, 3'h0)
		run(LFB_OP_CALL, 1'b1, 16'h000F);
		`CHK({jump_o, jump_sub_o, depth_o, rung_out_o}, {1'b1, 8'h0F, 2'h1, 1'b0})
		// Nested call on small model refused
		run(LFB_OP_CALL, 1'b1, 16'h0002);
		`CHK({call_err_o, jump_o, depth_o}, 4'h9)
		run(LFB_OP_EXIT, 1'b1, 16'h0000);
		`CHK({resume_o, depth_o}, 3'h4)
		run(LFB_OP_EXIT, 1'b1, 16'h0000);
		`CHK({resume_o, depth_o}, 3'h0)
		@(posedge sys_clk_i);
		large_model_i <= 1'b1;
		for (int i = 1; i <= 3; i++) begin
			run(LFB_OP_CALL, 1'b1, 16'h00FF);
			`CHK({jump_o, jump_sub_o, depth_o}, {1'b1, 8'hFF, 2'(i)})
		end
		run(LFB_OP_CALL, 1'b1, 16'h0004);
		`CHK({call_err_o, jump_o, depth_o}, 4'hB)
		for (int i = 2; i >= 0; i--) begin
			run(LFB_OP_EXIT, 1'b1, 16'h0000);
			`CHK({resume_o, depth_o}, {1'b1, 2'(i)})
		end
	endtask : chk_calls

	task automatic chk_loop();
		// One start, one end, own rungs
		run(LFB_OP_LOOP, 1'b1, 16'h0003);
		`CHK(rung_out_o, 1'b1)
		repeat (2) begin
			run(LFB_OP_NEXT, 1'b1, 16'h0000);
			`CHK({loop_back_o, loop_exit_o}, 2'h2)
		end
		run(LFB_OP_NEXT, 1'b1, 16'h0000);
		`CHK({loop_back_o, loop_exit_o}, 2'h1)
		run(LFB_OP_LOOP, 1'b1, 16'h0005);
		run(LFB_OP_NEXT, 1'b1, 16'h0000);
		`CHK(loop_back_o, 1'b1)
		run(LFB_OP_NEXT, 1'b0, 16'h0000);
		`CHK({loop_back_o, loop_exit_o, rung_out_o}, 3'h2)
		run(LFB_OP_LOOP, 1'b0, 16'h0005);
		`CHK(rung_out_o, 1'b0)
		run(LFB_OP_NEXT, 1'b1, 16'h0000);
		`CHK({loop_back_o, loop_exit_o}, 2'h1)
		// Count one, and zero clipped to one
		run(LFB_OP_LOOP, 1'b1, 16'h0001);
		run(LFB_OP_NEXT, 1'b1, 16'h0000);
		`CHK({loop_back_o, loop_exit_o}, 2'h1)
		run(LFB_OP_LOOP, 1'b1, 16'h0000);
		run(LFB_OP_NEXT, 1'b1, 16'h0000);
		`CHK({loop_back_o, loop_exit_o}, 2'h1)
	endtask : chk_loop

	task automatic chk_irq();
		run(LFB_OP_IRQ, 1'b1, 16'h0000);
		`CHK(irq_en_o, 1'b1)
		run(LFB_OP_IRQ, 1'b1, 16'h0001);
		`CHK(irq_en_o, 1'b0)
		@(posedge sys_clk_i);
		irq_cause_i <= 2'h3;
		@(posedge sys_clk_i);
		irq_cause_i <= 2'h0;
		#1;
		`CHK({irq_pend_o, irq_run_o}, 3'h6)
		run(LFB_OP_IRQ, 1'b1, 16'h0000);
		`CHK({irq_en_o, irq_run_o}, 2'h2)
		@(posedge sys_clk_i);
		#1;
		`CHK({irq_run_o, irq_sel_o, irq_pend_o}, 5'h16)
		// Done frees the gate; the second pending cause is serviced next
		@(posedge sys_clk_i);
		irq_done_i <= 1'b1;
		@(posedge sys_clk_i);
		irq_done_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		`CHK({irq_run_o, irq_sel_o, irq_pend_o}, 5'h18)
		// Mid-run reset must drop every held result
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK({table_o, tally_o, depth_o, irq_en_o, irq_pend_o, irq_run_o, irq_sel_o}, 56'h0)
		run(LFB_OP_EXPAND, 1'b1, 16'h0005);
		`CHK({table_o, rung_out_o}, {32'h00000020, 1'b1})
	endtask : chk_irq

	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		#80000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		{rst_i, large_model_i, exec_i, rung_in_i, irq_off_i, irq_done_i} = 6'h20;
		op_i = LFB_OP_NONE;
		{src_i, sub_num_i, loop_n_i, irq_cause_i} = '0;
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK({table_o, tally_o, depth_o, irq_en_o, irq_pend_o, rung_out_o}, 54'h0)
		chk_expand();
		chk_tally();
		chk_calls();
		chk_loop();
		chk_irq();
		stop_test();
	end
endmodule : tb_ladder_flow_and_bit_ops
